// *** hdl/dio_pkg.sv ***
// constants for the port-mapped 32-channel digital input/output block
package dio_pkg;
    localparam logic [1:0]  OFS_ISOLATED_LOW  = 2'h0;
    localparam logic [1:0]  OFS_ISOLATED_HIGH = 2'h1;
    localparam logic [1:0]  OFS_TTL_LOW       = 2'h2;
    localparam logic [1:0]  OFS_TTL_HIGH      = 2'h3;
    localparam int          CHANNELS          = 16;
    localparam int          ADDR_WIDTH        = 10;
    localparam int          SWITCH_WIDTH      = 8;
    localparam logic [15:0] OUTPUT_RESET      = 16'h0000;
    // switch value for base 300h (A9..A2 = 1100_0000)
    localparam logic [7:0]  BASE_DEFAULT_SWITCH = 8'hC0;
    // switch position that carries A9; must be set for bases 200h..3FCh
    localparam int          SWITCH_A9_BIT     = 7;
endpackage

// *** hdl/isa_digital_io_ports.sv ***
// isa i/o-mapped isolated and ttl digital input/output ports
`timescale 1ns/100ps
// Function
// - each register bit is one channel
// - writing one turns output channel on
// - reads return present input levels
// - four byte locations from selected base
// - offset 0: isolated channels 0-7
// - offset 1: isolated channels 8-15
// - offset 2: ttl channels 0-7
// - offset 3: ttl channels 8-15
// - sixteen ttl inputs and outputs too
// - decode A9..A2 against switch setting
// - base range 200h to 3FCh
// - default switch gives base 300h
module isa_digital_io_ports (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [9:0]  sa,
    input  wire logic        aen,
    input  wire logic        ior_n,
    input  wire logic        iow_n,
    input  wire logic [7:0]  sd_in,
    output logic      [7:0]  sd_out,
    output logic             sd_oe,
    input  wire logic [7:0]  base_select_switch,
    input  wire logic [15:0] isolated_input,
    input  wire logic [15:0] ttl_input,
    output logic      [15:0] isolated_output,
    output logic      [15:0] ttl_output
);
    // every pin but reset_n is asynchronous to clk: two flops before any logic
    logic [9:0]  sa_s1, sa_s2;
    logic        aen_s1, aen_s2;
    logic        ior_s1, ior_s2;
    logic        iow_s1, iow_s2, iow_s3;
    logic [7:0]  sd_s1, sd_s2;
    logic [7:0]  sw_s1, sw_s2;
    logic [15:0] iso_s1, iso_s2;
    logic [15:0] ttl_s1, ttl_s2;
    logic        selected;
    logic        write_pulse;
    logic        read_active;
    logic [7:0]  next_read;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sa_s1  <= 10'h000;
            sa_s2  <= 10'h000;
            aen_s1 <= 1'b1;
            aen_s2 <= 1'b1;
            ior_s1 <= 1'b1;
            ior_s2 <= 1'b1;
            iow_s1 <= 1'b1;
            iow_s2 <= 1'b1;
            iow_s3 <= 1'b1;
            sd_s1  <= 8'h00;
            sd_s2  <= 8'h00;
            sw_s1  <= 8'h00;
            sw_s2  <= 8'h00;
            iso_s1 <= 16'h0000;
            iso_s2 <= 16'h0000;
            ttl_s1 <= 16'h0000;
            ttl_s2 <= 16'h0000;
        end else begin
            sa_s1  <= sa;
            sa_s2  <= sa_s1;
            aen_s1 <= aen;
            aen_s2 <= aen_s1;
            ior_s1 <= ior_n;
            ior_s2 <= ior_s1;
            iow_s1 <= iow_n;
            iow_s2 <= iow_s1;
            iow_s3 <= iow_s2;
            sd_s1  <= sd_in;
            sd_s2  <= sd_s1;
            sw_s1  <= base_select_switch;
            sw_s2  <= sw_s1;
            iso_s1 <= isolated_input;
            iso_s2 <= iso_s1;
            ttl_s1 <= ttl_input;
            ttl_s2 <= ttl_s1;
        end
    end

    // dma cycles (aen high) never hit the card; a9 switch off is outside
    // the legal base range, so the card then answers nowhere
    assign selected = !aen_s2 && sw_s2[dio_pkg::SWITCH_A9_BIT]
                      && (sa_s2[9:2] == sw_s2);
    // the write is taken once, on the synchronised falling strobe; the
    // host holds data valid through the strobe so it is stable by then
    assign write_pulse = selected && !iow_s2 && iow_s3;
    assign read_active = selected && !ior_s2;

    // one always_ff per output bank; untouched bytes keep their value
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            isolated_output <= dio_pkg::OUTPUT_RESET;
        end else if (write_pulse) begin
            if (sa_s2[1:0] == dio_pkg::OFS_ISOLATED_LOW) begin
                isolated_output[7:0] <= sd_s2;
            end else if (sa_s2[1:0] == dio_pkg::OFS_ISOLATED_HIGH) begin
                isolated_output[15:8] <= sd_s2;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ttl_output <= dio_pkg::OUTPUT_RESET;
        end else if (write_pulse) begin
            if (sa_s2[1:0] == dio_pkg::OFS_TTL_LOW) begin
                ttl_output[7:0] <= sd_s2;
            end else if (sa_s2[1:0] == dio_pkg::OFS_TTL_HIGH) begin
                ttl_output[15:8] <= sd_s2;
            end
        end
    end

    // reads see inputs only; output latches are not readable
    always_comb begin
        if (sa_s2[1:0] == dio_pkg::OFS_ISOLATED_LOW) begin
            next_read = iso_s2[7:0];
        end else if (sa_s2[1:0] == dio_pkg::OFS_ISOLATED_HIGH) begin
            next_read = iso_s2[15:8];
        end else if (sa_s2[1:0] == dio_pkg::OFS_TTL_LOW) begin
            next_read = ttl_s2[7:0];
        end else begin
            next_read = ttl_s2[15:8];
        end
    end

    // levels are resampled every cycle while the read strobe is low
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sd_out <= 8'h00;
            sd_oe  <= 1'b0;
        end else begin
            sd_out <= read_active ? next_read : 8'h00;
            sd_oe  <= read_active;
        end
    end

    // ---------------- assertions ----------------
    a_reset_clears: assert property (@(posedge clk)
        !reset_n |=> (isolated_output == 16'h0000) && (ttl_output == 16'h0000))
        else $error("outputs not cleared by reset");

    a_iso_low_write: assert property (@(posedge clk)
        disable iff (!reset_n)
        write_pulse && sa_s2[1:0] == 2'h0
        |=> isolated_output[7:0] == $past(sd_s2) && $stable(ttl_output))
        else $error("isolated low byte write lost");

    a_iso_high_write: assert property (@(posedge clk)
        disable iff (!reset_n)
        write_pulse && sa_s2[1:0] == 2'h1
        |=> isolated_output[15:8] == $past(sd_s2)
            && isolated_output[7:0] == $past(isolated_output[7:0]))
        else $error("isolated high byte write lost");

    a_ttl_low_write: assert property (@(posedge clk)
        disable iff (!reset_n)
        write_pulse && sa_s2[1:0] == 2'h2
        |=> ttl_output[7:0] == $past(sd_s2) && $stable(isolated_output))
        else $error("ttl low byte write lost");

    a_ttl_high_write: assert property (@(posedge clk)
        disable iff (!reset_n)
        write_pulse && sa_s2[1:0] == 2'h3
        |=> ttl_output[15:8] == $past(sd_s2))
        else $error("ttl high byte write lost");

    a_outputs_hold: assert property (@(posedge clk)
        disable iff (!reset_n)
        !write_pulse |=> $stable(isolated_output) && $stable(ttl_output))
        else $error("output changed without a write");

    a_decode_match: assert property (@(posedge clk)
        disable iff (!reset_n)
        !ior_s2 && !aen_s2 && sw_s2[7] && sa_s2[9:2] == sw_s2
        |=> sd_oe)
        else $error("matching read not answered");

    a_no_foreign: assert property (@(posedge clk)
        disable iff (!reset_n)
        (aen_s2 || !sw_s2[7] || sa_s2[9:2] != sw_s2) |=> !sd_oe)
        else $error("card answered outside its window");

    a_read_levels: assert property (@(posedge clk)
        disable iff (!reset_n)
        read_active && sa_s2[1:0] == 2'h2 |=> sd_out == $past(ttl_s2[7:0]))
        else $error("read did not return ttl input levels");

    a_read_iso: assert property (@(posedge clk)
        disable iff (!reset_n)
        read_active && sa_s2[1:0] == 2'h1 |=> sd_out == $past(iso_s2[15:8]))
        else $error("read did not return isolated input levels");

    a_read_iso_low: assert property (@(posedge clk)
        disable iff (!reset_n)
        read_active && sa_s2[1:0] == 2'h0 |=> sd_out == $past(iso_s2[7:0]))
        else $error("read did not return isolated low input levels");

    a_read_ttl_high: assert property (@(posedge clk)
        disable iff (!reset_n)
        read_active && sa_s2[1:0] == 2'h3 |=> sd_out == $past(ttl_s2[15:8]))
        else $error("read did not return ttl high input levels");

    // a quiet data bus keeps the card from fighting other i/o devices
    a_idle_quiet: assert property (@(posedge clk)
        disable iff (!reset_n)
        !read_active |=> !sd_oe && sd_out == 8'h00)
        else $error("data bus driven without a selected read");

    c_write_each: cover property (@(posedge clk) disable iff (!reset_n)
        write_pulse ##[1:50] write_pulse);
    c_read_default: cover property (@(posedge clk)
        disable iff (!reset_n)
        read_active && sw_s2 == dio_pkg::BASE_DEFAULT_SWITCH);
    c_on_then_read: cover property (@(posedge clk) disable iff (!reset_n)
        write_pulse ##[1:20] read_active);
    c_refused_write: cover property (@(posedge clk) disable iff (!reset_n)
        !iow_s2 && iow_s3 && !selected);
    c_both_banks: cover property (@(posedge clk) disable iff (!reset_n)
        write_pulse && !sa_s2[1] ##[1:40] write_pulse && sa_s2[1]);
endmodule

// *** test/isa_host_model.sv ***
// host processor model issuing isa i/o read and write cycles
`timescale 1ns/100ps
module isa_host_model (
    input  wire logic       clk,
    output logic      [9:0] sa,
    output logic            aen,
    output logic            ior_n,
    output logic            iow_n,
    output logic      [7:0] sd_in,
    input  wire logic [7:0] sd_out,
    input  wire logic       sd_oe
);
    initial begin
        sa = 10'h000;
        aen = 1'b1;
        ior_n = 1'b1;
        iow_n = 1'b1;
        sd_in = 8'h00;
    end
    // one whole cycle: address first, strobe 5 edges, then 4 idle edges
    task automatic cycle(input logic [9:0] a, input logic en, wr,
        input logic [7:0] d, output logic [7:0] q, output logic oe);
        @(posedge clk);
        sa <= a;
        aen <= en;
        sd_in <= d;
        repeat (3) @(posedge clk);
        if (wr) iow_n <= 1'b0;
        else ior_n <= 1'b0;
        repeat (5) @(posedge clk);
        q = sd_out;
        oe = sd_oe;
        iow_n <= 1'b1;
        ior_n <= 1'b1;
        // released bus: inverse pattern, never the stale byte
        sd_in <= ~d;
        repeat (4) @(posedge clk);
    endtask
endmodule

// *** test/testbench.sv ***
// self-checking bench for the isa digital i/o ports
`timescale 1ns/100ps
module testbench;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [9:0]  sa, a;
    logic        aen, ior_n, iow_n, sd_oe, oe;
    logic [7:0]  sd_in, sd_out, q, b, d;
    logic [7:0]  sw = 8'hC0;
    logic [15:0] iso_in = 16'h0000, ttl_in = 16'h0000;
    logic [15:0] iso_out, ttl_out;
    int          err_count = 0, n_tests = 0, cycles = 0, k;
    int          outs[4];
    isa_digital_io_ports i_isa_digital_io_ports (.clk(clk),
        .reset_n(reset_n), .sa(sa), .aen(aen), .ior_n(ior_n),
        .iow_n(iow_n), .sd_in(sd_in), .sd_out(sd_out), .sd_oe(sd_oe),
        .base_select_switch(sw), .isolated_input(iso_in),
        .ttl_input(ttl_in), .isolated_output(iso_out),
        .ttl_output(ttl_out));
    isa_host_model i_isa_host_model (.clk(clk), .sa(sa), .aen(aen),
        .ior_n(ior_n), .iow_n(iow_n), .sd_in(sd_in), .sd_out(sd_out),
        .sd_oe(sd_oe));
    initial forever #2 clk = ~clk;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic check_outs;
        check(iso_out, 16'(outs[1] * 256 + outs[0]));
        check(ttl_out, 16'(outs[3] * 256 + outs[2]));
    endtask
    function automatic logic [7:0] in_byte(input int n);
        int v;
        v = (n < 2) ? int'(iso_in) : int'(ttl_in);
        return 8'((v >> (8 * (n % 2))) & 255);
    endfunction
    task automatic final_report;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // a normal run ends well before this ceiling (about 720 of 20000 cycles); only a hang reaches it
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            final_report();
        end
    end
    initial begin
        void'($urandom(32'h5010d940));
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        check_outs();
        for (int i = 0; i < 24; i++) begin
            k = i % 4;
            b = (i < 8) ? 8'hC0 : (i < 16) ? 8'h80 : 8'hFC;
            sw <= b;
            d = 8'($urandom);
            iso_in <= 16'($urandom);
            ttl_in <= 16'($urandom);
            i_isa_host_model.cycle({b, 2'(k)}, 1'b0, 1'b1, d, q, oe);
            outs[k] = d;
            check_outs();
            i_isa_host_model.cycle({b, 2'(k)}, 1'b0, 1'b0, d, q, oe);
            check({15'h0, oe}, 16'h0001);
            check({8'h00, q}, {8'h00, in_byte(k)});
            check({sd_oe, 7'h00, sd_out}, 16'h0000);
        end
        for (int j = 0; j < 3; j++) begin
            b = (j == 2) ? 8'h40 : 8'hFC;
            sw <= b;
            a = (j == 1) ? {8'hFD, 2'h1} : {b, 2'h1};
            i_isa_host_model.cycle(a, j == 0, 1'b1, 8'hFF, q, oe);
            check_outs();
            i_isa_host_model.cycle(a, j == 0, 1'b0, 8'h00, q, oe);
            check({15'h0, oe}, 16'h0000);
        end
        reset_n <= 1'b0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        outs = '{0, 0, 0, 0};
        repeat (3) @(posedge clk);
        check_outs();
        final_report();
    end
endmodule
